// *** core/sps_consts.svh ***
// Constants for the serial slave port with ready flow control
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
// How it works
// - Shift clock comes from the external master; the port never generates it.
// - Dual transmit drives the master-out lane besides the slave-out lane.
// - Quad transmit drives master-out and extra lanes two and three as outputs.
// - Dual receive samples the slave-out lane together with master-out.
// - Quad receive samples slave-out and both extra lanes with master-out.
// - Lane outputs enable only after select asserts, release after select deasserts; the ready drive enable follows flow control enable alone.
// - Ready line gives flow control; master holds off while it is low.
// - Receive ready drops 2.5 to 3.5 system clocks after valid clock edge; the port drops it 4 to 5 clocks after.
// - Transmit ready drops 3.5 to 4.5 system clocks after valid clock edge; the port drops it 5 to 6 clocks after.
// - Flow direction select 0 picks receive ready, 1 picks transmit ready.
// - Polarity and phase in control register; lead, lag, stop in delay register.

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPS_ADDR_W          4
`define SPS_OFF_CTL         4'h0
`define SPS_OFF_DLY         4'h4
`define SPS_OFF_TXD         4'h8
`define SPS_OFF_RXD         4'hC

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPS_CTL_EN          0
`define SPS_CTL_CPOL        1
`define SPS_CTL_CPHA        2
`define SPS_CTL_TX          3
`define SPS_CTL_LANE_LO     4
`define SPS_CTL_LANE_HI     5
`define SPS_CTL_FCEN        6
`define SPS_CTL_FCDIR       7
`define SPS_CTL_ODM         8
`define SPS_CTL_RST         9'h000
`define SPS_DLY_RST         12'h000

// ----------------------------------------------------------------
// Ready timing in tenths of a system clock period
// ----------------------------------------------------------------
`define SPS_RDY_RX_MIN_X10  25
`define SPS_RDY_TX_MIN_X10  35
`endif

// *** core/sps_pkg.sv ***
// Types for the serial slave port
package sps_pkg;
	typedef enum logic [1:0] {
		SPS_SINGLE = 2'h0,
		SPS_DUAL   = 2'h1,
		SPS_QUAD   = 2'h2
	} sps_lane_e;

	typedef enum logic [2:0] {
		SPS_ST_IDLE = 3'h1,
		SPS_ST_WAIT = 3'h2,
		SPS_ST_HOLD = 3'h4
	} sps_rdy_e;

	typedef struct packed {
		logic [3:0] i;
		logic [3:0] o;
		logic [3:0] oe;
	} sps_lanes_s;
endpackage

// *** core/sps_sync.sv ***
// Two-flop synchroniser, one per bit
`timescale 1ns/1ns
module sps_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// *** core/sps_port.sv ***
// Serial slave port with multi-lane data and ready flow control
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "sps_consts.svh"
module sps_port #(
	parameter int DATA_W = 8
) (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic [`SPS_ADDR_W-1:0] addr,
	input  wire logic [31:0]            wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic      [31:0]            rdata,
	input  wire logic                   serial_clk,
	input  wire logic                   sel_n,
	input  wire sps_pkg::sps_lanes_s    lanes_in,
	output sps_pkg::sps_lanes_s         lanes_out,
	output logic                        ready,
	output logic                        ready_oe
);
	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	logic [5:0] sync_q;
	logic       sclk_s;
	logic       sel_n_s;
	logic [3:0] din_s;

	// Serial clock, select and lanes are all foreign to clk
	sps_sync #(
		.W (6)
	) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    ({serial_clk, sel_n, lanes_in.i}),
		.q    (sync_q)
	);
	assign sclk_s  = sync_q[5];
	assign sel_n_s = sync_q[4];
	assign din_s   = sync_q[3:0];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [8:0]        ctl_reg;
	logic [11:0]       dly_reg;
	logic [DATA_W-1:0] txd_reg;
	logic [DATA_W-1:0] rxd_reg;
	logic              rx_full_reg;
	logic              tx_empty_reg;
	logic              done_evt;
	logic [DATA_W-1:0] rx_shift_reg;

	// Polarity and phase live in control, delays in delay register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctl_reg <= `SPS_CTL_RST;
			dly_reg <= `SPS_DLY_RST;
		end else if (wr) begin
			if (addr == `SPS_OFF_CTL)
				ctl_reg <= wdata[8:0];
			if (addr == `SPS_OFF_DLY)
				dly_reg <= wdata[11:0];
		end
	end

	// Transmit word and empty flag; a word end sets empty over a write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txd_reg      <= '0;
			tx_empty_reg <= 1'b1;
		end else begin
			if (wr && addr == `SPS_OFF_TXD) begin
				txd_reg      <= wdata[DATA_W-1:0];
				tx_empty_reg <= 1'b0;
			end
			if (done_evt && ctl_reg[`SPS_CTL_TX])
				tx_empty_reg <= 1'b1;
		end
	end

	// Receive word and full flag; a new word wins over the read clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rxd_reg     <= '0;
			rx_full_reg <= 1'b0;
		end else begin
			if (rd && addr == `SPS_OFF_RXD)
				rx_full_reg <= 1'b0;
			if (done_evt && !ctl_reg[`SPS_CTL_TX]) begin
				rxd_reg     <= rx_shift_reg;
				rx_full_reg <= 1'b1;
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (rd) begin
			case (addr)
				`SPS_OFF_CTL: rdata <= {23'h0, ctl_reg};
				`SPS_OFF_DLY: rdata <= {20'h0, dly_reg};
				`SPS_OFF_TXD: rdata <= {tx_empty_reg, 31'(txd_reg)};
				`SPS_OFF_RXD: rdata <= {rx_full_reg, 31'(rxd_reg)};
				default:      rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Serial clock edges
	// ----------------------------------------------------------------
	logic               sclk_d_reg;
	logic               lead_edge;
	logic               trail_edge;
	logic               samp_edge;
	logic               drv_edge;
	logic               active;
	sps_pkg::sps_lane_e lane_mode;
	logic [2:0]         step;

	assign lane_mode = sps_pkg::sps_lane_e'(ctl_reg[`SPS_CTL_LANE_HI:`SPS_CTL_LANE_LO]);
	assign active    = ctl_reg[`SPS_CTL_EN] && !sel_n_s;
	// Clock is only observed, never generated here
	assign lead_edge  = (sclk_s != sclk_d_reg) && (sclk_s != ctl_reg[`SPS_CTL_CPOL]);
	assign trail_edge = (sclk_s != sclk_d_reg) && (sclk_s == ctl_reg[`SPS_CTL_CPOL]);
	assign samp_edge  = active && (ctl_reg[`SPS_CTL_CPHA] ? trail_edge : lead_edge);
	assign drv_edge   = active && (ctl_reg[`SPS_CTL_CPHA] ? lead_edge : trail_edge);
	assign step = (lane_mode == sps_pkg::SPS_QUAD) ? 3'h4 :
	              (lane_mode == sps_pkg::SPS_DUAL) ? 3'h2 : 3'h1;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			sclk_d_reg <= 1'b0;
		else
			sclk_d_reg <= sclk_s;
	end

	// ----------------------------------------------------------------
	// Shifting
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] tx_shift_reg;
	logic [7:0]        bit_cnt_reg;
	logic [DATA_W-1:0] rx_next;
	logic [3:0]        out_bits;

	// Lanes sampled per width: slave-out joins in dual, all four in quad
	always_comb begin
		case (lane_mode)
			sps_pkg::SPS_QUAD: rx_next = {rx_shift_reg[DATA_W-5:0],
				din_s[3], din_s[2], din_s[1], din_s[0]};
			sps_pkg::SPS_DUAL: rx_next = {rx_shift_reg[DATA_W-3:0],
				din_s[1], din_s[0]};
			default:           rx_next = {rx_shift_reg[DATA_W-2:0], din_s[0]};
		endcase
	end

	// Lane 0 master-out, 1 slave-out, 2 and 3 extra lanes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_shift_reg <= '0;
			tx_shift_reg <= '0;
			bit_cnt_reg  <= '0;
			done_evt     <= 1'b0;
		end else begin
			done_evt <= 1'b0;
			if (!active) begin
				bit_cnt_reg  <= '0;
				tx_shift_reg <= txd_reg;
			end else begin
				if (samp_edge) begin
					rx_shift_reg <= rx_next;
					if (bit_cnt_reg + 8'(step) >= 8'(DATA_W)) begin
						bit_cnt_reg  <= '0;
						done_evt     <= 1'b1;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 8'(step);
					end
				end
				if (drv_edge)
					tx_shift_reg <= (bit_cnt_reg == 8'h0) ? txd_reg :
						tx_shift_reg << step;
			end
		end
	end

	// Output bits follow the shifter one clock later, so a shift on a drive
	// edge reaches the lanes long before the master's next sampling edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			out_bits <= '0;
		else if (!active)
			out_bits <= '0;
		else
			case (lane_mode)
				sps_pkg::SPS_QUAD: out_bits <= tx_shift_reg[DATA_W-1:DATA_W-4];
				sps_pkg::SPS_DUAL: out_bits <= {2'h0, tx_shift_reg[DATA_W-1:DATA_W-2]};
				default:           out_bits <= {2'h0, tx_shift_reg[DATA_W-1], 1'b0};
			endcase
	end

	// Enables follow select; direction picks which lanes drive
	logic [3:0] oe_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			oe_reg <= '0;
		else if (!active)
			oe_reg <= '0;
		else if (ctl_reg[`SPS_CTL_TX])
			case (lane_mode)
				sps_pkg::SPS_QUAD: oe_reg <= 4'hF;
				sps_pkg::SPS_DUAL: oe_reg <= 4'h3;
				default:           oe_reg <= 4'h2;
			endcase
		else if (lane_mode == sps_pkg::SPS_SINGLE)
			oe_reg <= 4'h2;
		else
			oe_reg <= 4'h0;
	end

	// Open drain mode only pulls low: drive enable only for zeros
	always_comb begin
		lanes_out.o  = ctl_reg[`SPS_CTL_ODM] ? 4'h0 : out_bits;
		lanes_out.oe = ctl_reg[`SPS_CTL_ODM] ? (oe_reg & ~out_bits) : oe_reg;
		lanes_out.i  = 4'h0;
	end

	// ----------------------------------------------------------------
	// Ready flow control
	// ----------------------------------------------------------------
	localparam int RX_DLY = (`SPS_RDY_RX_MIN_X10 + 9) / 10;
	localparam int TX_DLY = (`SPS_RDY_TX_MIN_X10 + 9) / 10;

	sps_pkg::sps_rdy_e rdy_st_reg;
	logic [2:0]        rdy_cnt_reg;
	logic [2:0]        rdy_tgt;
	logic              busy;

	// Receive counts from sync'd edge (2 sync + 1), transmit one more
	assign rdy_tgt = ctl_reg[`SPS_CTL_FCDIR] ? 3'(TX_DLY - 3) : 3'(RX_DLY - 3);
	// Word still unserved: receive unread or transmit not refilled
	assign busy = ctl_reg[`SPS_CTL_FCDIR] ? tx_empty_reg : rx_full_reg;

	// Edge seen only after two-flop resync of the serial clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdy_st_reg  <= sps_pkg::SPS_ST_IDLE;
			rdy_cnt_reg <= '0;
		end else begin
			case (rdy_st_reg)
				sps_pkg::SPS_ST_IDLE:
					if (done_evt && ctl_reg[`SPS_CTL_FCEN]) begin
						rdy_st_reg  <= sps_pkg::SPS_ST_WAIT;
						rdy_cnt_reg <= '0;
					end
				sps_pkg::SPS_ST_WAIT:
					if (rdy_cnt_reg >= rdy_tgt)
						rdy_st_reg <= sps_pkg::SPS_ST_HOLD;
					else
						rdy_cnt_reg <= rdy_cnt_reg + 3'h1;
				sps_pkg::SPS_ST_HOLD:
					if (!busy || !ctl_reg[`SPS_CTL_FCEN])
						rdy_st_reg <= sps_pkg::SPS_ST_IDLE;
				default: rdy_st_reg <= sps_pkg::SPS_ST_IDLE;
			endcase
		end
	end

	// Master must pause while ready is low
	assign ready    = (rdy_st_reg != sps_pkg::SPS_ST_HOLD);
	assign ready_oe = ctl_reg[`SPS_CTL_FCEN];
endmodule

// *** verification/sps_monitor.sv ***
// Checker for the serial slave port, bound to its top module
`timescale 1ns/1ns
module sps_monitor #(
	parameter int DATA_W = 8
) (
	input wire logic                clk,
	input wire logic                rstn,
	input wire logic [3:0]          addr,
	input wire logic [31:0]         wdata,
	input wire logic                wr,
	input wire logic                rd,
	input wire logic [31:0]         rdata,
	input wire logic                serial_clk,
	input wire logic                sel_n,
	input wire sps_pkg::sps_lanes_s lanes_in,
	input wire sps_pkg::sps_lanes_s lanes_out,
	input wire logic                ready,
	input wire logic                ready_oe
);
	// ------------------------------------------------
	// Shadow control word and age of the sampling edge
	// ------------------------------------------------
	logic [8:0] ctl_reg;
	logic       samp_reg;
	logic [7:0] since_reg;
	logic       samp;
	logic [3:0] tx_oe;
	// Sampling edge is rising when polarity equals phase
	assign samp  = serial_clk ^ ctl_reg[1] ^ ctl_reg[2];
	assign tx_oe = (ctl_reg[5:4] == 2'h0) ? 4'h2 : (ctl_reg[5:4] == 2'h1) ? 4'h3 : 4'hF;
	// Control word as last written
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctl_reg <= 9'h000;
		end else if (wr && addr == 4'h0) begin
			ctl_reg <= wdata[8:0];
		end
	end
	// Saturating age counter, so a long idle cannot wrap into the window
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			samp_reg  <= 1'b0;
			since_reg <= 8'hFF;
		end else begin
			samp_reg  <= samp;
			since_reg <= (samp && !samp_reg) ? 8'h00 : since_reg + {7'h0, since_reg != 8'hFF};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_rd_ctl;
		rd && addr == 4'h0;
	endsequence
	sequence s_word_end;
		$fell(ready);
	endsequence
	a_ctl_read: assert property (s_rd_ctl |=> rdata[8:0] == ctl_reg)
		else $error("control word read back wrong");
	a_flow_oe: assert property (wr && addr == 4'h0 |=> ready_oe == $past(wdata[6]))
		else $error("ready drive enable wrong");
	a_oe_idle: assert property (sel_n [*6] |-> lanes_out.oe == 4'h0)
		else $error("lane driven while not selected");
	a_oe_start: assert property ($rose(|lanes_out.oe) |-> !$past(sel_n))
		else $error("lane enabled before select");
	a_rx_inputs: assert property (!ctl_reg[3] && ctl_reg[5:4] != 2'h0 |-> lanes_out.oe == 4'h0)
		else $error("lane driven in wide receive");
	a_tx_lanes: assert property (ctl_reg[3] && |lanes_out.oe |-> lanes_out.oe == tx_oe)
		else $error("wrong lanes driven in transmit");
	a_rdy_rx: assert property (s_word_end ##0 !ctl_reg[7] |-> since_reg inside {[2:7]})
		else $error("receive ready fell out of window");
	a_rdy_tx: assert property (s_word_end ##0 ctl_reg[7] |-> since_reg inside {[3:8]})
		else $error("transmit ready fell out of window");
	a_rdy_rise: assert property ($rose(ready) |-> $past(rd | wr) || $past(rd | wr, 2))
		else $error("ready rose without service");
endmodule
bind sps_port sps_monitor #(.DATA_W(DATA_W)) u_mon (.clk(clk), .rstn(rstn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_clk(serial_clk), .sel_n(sel_n),
	.lanes_in(lanes_in), .lanes_out(lanes_out), .ready(ready), .ready_oe(ready_oe));

// *** verification/sps_master_model.sv ***
// Behavioural external master for the serial slave port
`timescale 1ns/1ns
module sps_master_model (
	output logic            serial_clk,
	output logic            sel_n,
	output logic [3:0]      drive,
	input  wire logic [3:0] lanes,
	input  wire logic       ready
);
	// Clock stands low and select high between frames
	initial begin
		serial_clk = 1'b0;
		sel_n      = 1'b1;
		drive      = 4'h5;
	end
	// One byte MSB first, w lanes per edge; late sampling covers slave latency
	task automatic xfer(input logic [7:0] d, input int w, output logic [7:0] q);
		int         k;
		logic [3:0] m;
		k = 0;
		m = 4'((1 << w) - 1);
		while (!ready && k < 500) begin
			#8;
			k++;
		end
		q     = 8'h00;
		sel_n = 1'b0;
		#64;
		for (int b = 8 - w; b >= 0; b -= w) begin
			drive = (4'(d >> b) & m) | (~m & ~drive);
			#32;
			serial_clk = 1'b1;
			#28;
			q = (q << w) | 8'((w == 1) ? {3'h0, lanes[1]} : lanes & m);
			#4;
			serial_clk = 1'b0;
		end
		#32;
		sel_n = 1'b1;
		drive = ~drive; // Released lines do not keep the last value
	endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the serial slave port
`timescale 1ns/1ns
module tb;
	logic                clk = 1'b0;
	logic                rstn = 1'b0;
	logic [3:0]          addr = 4'h0;
	logic [31:0]         wdata = 32'h0;
	logic                wr = 1'b0;
	logic                rd = 1'b0;
	logic [31:0]         rdata;
	logic                serial_clk;
	logic                sel_n;
	logic                ready;
	logic                ready_oe;
	logic [3:0]          drive;
	sps_pkg::sps_lanes_s lanes_in;
	sps_pkg::sps_lanes_s lanes_out;
	int                  err_count = 0;
	int                  samples_checked = 0;
	logic [31:0]         q;
	logic [7:0]          got;
	// ------------------------------------------------
	// Rows: control word beside the byte it must carry
	// ------------------------------------------------
	logic [8:0]          row_ctl [6] = '{9'h0C9, 9'h041, 9'h0D9, 9'h051, 9'h0E9, 9'h061};
	logic [7:0]          row_dat [6] = '{8'hA5, 8'h3C, 8'h96, 8'h5A, 8'hC3, 8'h7E};
	always #4 clk = ~clk;
	// Wire level: the port wins where it drives, the master elsewhere
	assign lanes_in = '{i: (lanes_out.oe & lanes_out.o) | (~lanes_out.oe & drive), o: 4'h0, oe: 4'h0};
	sps_port #(.DATA_W(8)) dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .serial_clk(serial_clk), .sel_n(sel_n), .lanes_in(lanes_in),
		.lanes_out(lanes_out), .ready(ready), .ready_oe(ready_oe));
	sps_master_model m (.serial_clk(serial_clk), .sel_n(sel_n), .drive(drive),
		.lanes(lanes_in.i), .ready(ready));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		q = rdata;
	endtask
	// Bounded wait; running out ends the run as a failure
	task automatic wait_rdy(input logic lvl);
		int k;
		k = 0;
		while (ready !== lvl && k < 200) begin
			@(posedge clk);
			k++;
		end
		if (k == 200) begin
			err_count++;
			wrap_up();
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		#1;
		check(32'({ready, ready_oe, lanes_out.oe}), 32'h20);
		$display("reset test done");
		wr_reg(4'h4, 32'hFFFF_FFFF);
		rd_reg(4'h4);
		check(q, 32'h0000_0FFF);
		wr_reg(4'h2, 32'hFFFF_FFFF);
		rd_reg(4'h2);
		check(q, 32'h0);
		$display("register test done");
		for (int r = 0; r < 6; r++) begin
			wr_reg(4'h0, {23'h0, row_ctl[r]});
			if (row_ctl[r][3]) begin
				wr_reg(4'h8, {24'h0, row_dat[r]});
			end
			m.xfer(row_dat[r], (row_ctl[r][5:4] == 2'h0) ? 1 : 2 * row_ctl[r][5:4], got);
			wait_rdy(1'b0);
			if (row_ctl[r][3]) begin
				check({24'h0, got}, {24'h0, row_dat[r]});
				wr_reg(4'h8, 32'h0);
			end else begin
				rd_reg(4'hC);
				check({24'h0, q[7:0]}, {24'h0, row_dat[r]});
			end
			wait_rdy(1'b1);
			$display("row %0d done", r);
		end
		// Reset in mid-run while ready is held low must bring it back high
		m.xfer(8'h81, 4, got);
		wait_rdy(1'b0);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1;
		check(32'({ready, lanes_out.oe}), 32'h10);
		$display("second reset test done");
		wrap_up();
	end
endmodule
